/* File: adcfmt_consts.svh */
// Register addresses, field positions, reset values and timing counts
`ifndef ADCFMT_CONSTS_SVH
`define ADCFMT_CONSTS_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define ADCFMT_ADDR_LOW        8'hBD
`define ADCFMT_ADDR_HIGH       8'hBE
`define ADCFMT_ADDR_TRACK      8'hBA

// ************************************************************
// Reset values
// ************************************************************
`define ADCFMT_RST_LOW         8'h00
`define ADCFMT_RST_HIGH        8'h00
`define ADCFMT_RST_TRACK       8'hFF
`define ADCFMT_RD_UNMAPPED     8'h00

// ************************************************************
// Tracking configuration fields
// ************************************************************
`define ADCFMT_PWR_HI          7
`define ADCFMT_PWR_LO          4
`define ADCFMT_TM_HI           3
`define ADCFMT_TM_LO           2
`define ADCFMT_TK_HI           1
`define ADCFMT_TK_LO           0

// ************************************************************
// Repeat select codes
// ************************************************************
`define ADCFMT_RPT_1           2'h0
`define ADCFMT_RPT_4           2'h1
`define ADCFMT_RPT_8           2'h2
`define ADCFMT_RPT_16          2'h3

// ************************************************************
// Power-up timing
// ************************************************************
`define ADCFMT_PWR_STEP_NS     400
`define ADCFMT_CLK_NS          40
`define ADCFMT_PWR_STEP_CYC    ((`ADCFMT_PWR_STEP_NS + `ADCFMT_CLK_NS - 1) / `ADCFMT_CLK_NS)

`endif

/* File: adcfmt_pkg.sv */
// Types shared by the result formatting logic
package adcfmt_pkg;

	// Burst power sequencer states
	typedef enum logic [1:0] {
		ADCFMT_PWR_OFF,
		ADCFMT_PWR_WARM,
		ADCFMT_PWR_BUSY
	} adcfmt_pwr_state_t;

endpackage : adcfmt_pkg

/* File: adcfmt_burst_pwr.sv */
// Burst-mode power sequencer with programmable startup delay
`timescale 1ns/1ns
`default_nettype none
`include "adcfmt_consts.svh"

module adcfmt_burst_pwr
	import adcfmt_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       burst_mode_enable,
	input  wire logic       converter_enable,
	input  wire logic [3:0] burst_powerup_time,
	input  wire logic       conv_start,
	input  wire logic       conv_done,
	output logic            power_on_q,
	output logic            conv_go_q
);

	adcfmt_pwr_state_t  state_q, state_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	logic               power_on_d;
	logic               conv_go_d;
	logic [CNT_W-1:0]   step;
	logic [CNT_W-1:0]   delay;

	assign step  = CNT_W'(`ADCFMT_PWR_STEP_CYC);
	// Startup span (field + 1) steps, less the go cycle
	assign delay = CNT_W'((CNT_W'(burst_powerup_time) + 1'b1) * step - 1'b1);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		power_on_d = converter_enable;
		conv_go_d  = conv_start && converter_enable;
		if (burst_mode_enable && converter_enable) begin
			state_d    = ADCFMT_PWR_OFF;
			power_on_d = 1'b1; // R10
		end else if (burst_mode_enable) begin
			conv_go_d = 1'b0;
			case (state_q)
				ADCFMT_PWR_OFF: begin
					power_on_d = 1'b0;
					if (conv_start) begin // R9
						state_d    = ADCFMT_PWR_WARM;
						cnt_d      = delay;
						power_on_d = 1'b1;
					end
				end
				ADCFMT_PWR_WARM: begin
					power_on_d = 1'b1;
					if (cnt_q == '0) begin
						conv_go_d = 1'b1; // R9
						state_d   = ADCFMT_PWR_BUSY;
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
				ADCFMT_PWR_BUSY: begin
					power_on_d = !conv_done; // Back to low power
					if (conv_done) begin
						state_d = ADCFMT_PWR_OFF;
					end
				end
				default: begin
					state_d    = ADCFMT_PWR_OFF;
					power_on_d = 1'b0;
				end
			endcase
		end else begin
			state_d = ADCFMT_PWR_OFF;
		end
	end

	// Registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= ADCFMT_PWR_OFF;
			cnt_q      <= '0;
			power_on_q <= 1'b0;
			conv_go_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			power_on_q <= power_on_d;
			conv_go_q  <= conv_go_d;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_r9_go;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == ADCFMT_PWR_WARM && cnt_q == '0 && burst_mode_enable
			&& !converter_enable) |=> conv_go_q && power_on_q;
	endproperty
	a_r9_go: assert property (p_r9_go) // R9
		else $error("burst start not issued after warm-up");

	property p_r9_wake;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == ADCFMT_PWR_OFF && conv_start && burst_mode_enable
			&& !converter_enable) |=> power_on_q && !conv_go_q;
	endproperty
	a_r9_wake: assert property (p_r9_wake) // R9
		else $error("burst wake missing or go too early");

	property p_r10;
		@(posedge sys_clk) disable iff (sys_rst)
		(burst_mode_enable && converter_enable) [*2] |=> power_on_q;
	endproperty
	a_r10: assert property (p_r10) // R10
		else $error("converter dropped power in enabled burst");

	c_warm: cover property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == ADCFMT_PWR_WARM ##1 conv_go_q);

endmodule : adcfmt_burst_pwr
`default_nettype wire

/* File: adcfmt_result_regs.sv */
// Result formatting, data byte and tracking configuration registers
//
// What this block does
// (R1) Right-justify: high byte 4/6 bits by repeat
// (R2) Right-justify: high byte 7/8 bits by repeat
// (R3) Right-justify: unused high bits read zero
// (R4) Left-justify: high byte is result bits 11:4
// (R5) Software keeps repeat 00 when left-justifying
// (R6) Right-justify: low byte is sum bits 7:0
// (R7) Left-justify: low byte holds bits 3:0, zeros
// (R8) Tracking config eight bits, resets to FFh
// (R9) Burst, disabled: power up per start, delayed
// (R10) Burst, enabled: converter always stays powered
// (R11) Both bytes update together per completed result
`timescale 1ns/1ns
`default_nettype none
`include "adcfmt_consts.svh"

module adcfmt_result_regs
	import adcfmt_pkg::*;
#(
	parameter int SUM_W = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [7:0]       sfr_addr,
	input  wire logic             sfr_wr,
	input  wire logic [7:0]       sfr_wdata,
	input  wire logic             sfr_rd,
	output logic      [7:0]       sfr_rdata_q,
	input  wire logic [SUM_W-1:0] acc_result,
	input  wire logic             conv_done,
	input  wire logic             conv_start,
	input  wire logic             result_left_justify,
	input  wire logic [1:0]       accumulate_repeat_select,
	input  wire logic             burst_mode_enable,
	input  wire logic             converter_enable,
	output logic      [1:0]       track_mode_select,
	output logic      [1:0]       post_track_time,
	output logic                  converter_power_on,
	output logic                  conv_go
);

	logic [7:0] low_q, low_d;
	logic [7:0] high_q, high_d;
	logic [7:0] track_q, track_d;
	logic [7:0] rdata_d;
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	logic       wr_low;
	logic       wr_high;
	logic       wr_track;

	// ************************************************************
	// Result formatting
	// ************************************************************
	always_comb begin
		if (result_left_justify) begin
			// Single conversion only; repeat select is held at 00
			fmt_high = acc_result[11:4]; // R4 R5
			fmt_low  = {acc_result[3:0], 4'h0}; // R7
		end else begin
			fmt_low = acc_result[7:0]; // R6
			case (accumulate_repeat_select)
				`ADCFMT_RPT_1:  fmt_high = {4'h0, acc_result[11:8]}; // R1 R3
				`ADCFMT_RPT_4:  fmt_high = {2'h0, acc_result[13:8]}; // R1 R3
				`ADCFMT_RPT_8:  fmt_high = {1'h0, acc_result[14:8]}; // R2 R3
				`ADCFMT_RPT_16: fmt_high = acc_result[15:8]; // R2
				default:        fmt_high = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************
	assign wr_low   = sfr_wr && (sfr_addr == `ADCFMT_ADDR_LOW);
	assign wr_high  = sfr_wr && (sfr_addr == `ADCFMT_ADDR_HIGH);
	assign wr_track = sfr_wr && (sfr_addr == `ADCFMT_ADDR_TRACK);

	// Next values; a finished result beats a same-cycle software write
	always_comb begin
		low_d   = low_q;
		high_d  = high_q;
		track_d = track_q;
		if (conv_done) begin
			low_d  = fmt_low; // R11
			high_d = fmt_high; // R11
		end else begin
			if (wr_low) begin
				low_d = sfr_wdata;
			end
			if (wr_high) begin
				high_d = sfr_wdata;
			end
		end
		if (wr_track) begin
			track_d = sfr_wdata; // R8
		end
		case (sfr_addr)
			`ADCFMT_ADDR_LOW:   rdata_d = low_q;
			`ADCFMT_ADDR_HIGH:  rdata_d = high_q;
			`ADCFMT_ADDR_TRACK: rdata_d = track_q;
			default:            rdata_d = `ADCFMT_RD_UNMAPPED;
		endcase
		if (!sfr_rd) begin
			rdata_d = sfr_rdata_q; // Hold last read
		end
	end

	// Registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_q       <= `ADCFMT_RST_LOW;
			high_q      <= `ADCFMT_RST_HIGH;
			track_q     <= `ADCFMT_RST_TRACK; // R8
			sfr_rdata_q <= `ADCFMT_RD_UNMAPPED;
		end else begin
			low_q       <= low_d;
			high_q      <= high_d;
			track_q     <= track_d;
			sfr_rdata_q <= rdata_d;
		end
	end

	// Tracking fields go straight out of the config flop
	assign track_mode_select = track_q[`ADCFMT_TM_HI:`ADCFMT_TM_LO];
	assign post_track_time   = track_q[`ADCFMT_TK_HI:`ADCFMT_TK_LO];

	// ************************************************************
	// Burst power sequencing
	// ************************************************************
	adcfmt_burst_pwr u_pwr (
		.sys_clk            (sys_clk),
		.sys_rst            (sys_rst),
		.burst_mode_enable  (burst_mode_enable),
		.converter_enable   (converter_enable),
		.burst_powerup_time (track_q[`ADCFMT_PWR_HI:`ADCFMT_PWR_LO]),
		.conv_start         (conv_start),
		.conv_done          (conv_done),
		.power_on_q         (converter_power_on),
		.conv_go_q          (conv_go)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	property p_r1;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && !result_left_justify
			&& accumulate_repeat_select == `ADCFMT_RPT_4)
		|=> high_q == {2'h0, $past(acc_result[13:8])};
	endproperty
	a_r1: assert property (p_r1) // R1
		else $error("high byte wrong for repeat of four");

	property p_r2;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && !result_left_justify
			&& accumulate_repeat_select == `ADCFMT_RPT_16)
		|=> high_q == $past(acc_result[15:8]);
	endproperty
	a_r2: assert property (p_r2) // R2
		else $error("high byte wrong for repeat of sixteen");

	property p_r3;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && !result_left_justify
			&& accumulate_repeat_select == `ADCFMT_RPT_1)
		|=> high_q[7:4] == 4'h0 && high_q[3:0] == $past(acc_result[11:8]);
	endproperty
	a_r3: assert property (p_r3) // R3
		else $error("single result high byte not zero-filled");

	property p_r4;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && result_left_justify)
		|=> high_q == $past(acc_result[11:4]);
	endproperty
	a_r4: assert property (p_r4) // R4
		else $error("left-justified high byte wrong");

	property p_r6;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && !result_left_justify)
		|=> low_q == $past(acc_result[7:0]);
	endproperty
	a_r6: assert property (p_r6) // R6
		else $error("right-justified low byte wrong");

	property p_r7;
		@(posedge sys_clk) disable iff (sys_rst)
		(conv_done && result_left_justify)
		|=> low_q[3:0] == 4'h0 && low_q[7:4] == $past(acc_result[3:0]);
	endproperty
	a_r7: assert property (p_r7) // R7
		else $error("left-justified low byte wrong");

	property p_r8;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_track ##1 (sfr_rd && sfr_addr == `ADCFMT_ADDR_TRACK)
		|=> sfr_rdata_q == $past(sfr_wdata, 2);
	endproperty
	a_r8: assert property (p_r8) // R8
		else $error("tracking config does not read back");

	property p_r11;
		@(posedge sys_clk) disable iff (sys_rst)
		(!conv_done && !sfr_wr) |=> $stable(low_q) && $stable(high_q);
	endproperty
	a_r11: assert property (p_r11) // R11
		else $error("data bytes changed without a result");

	c_left: cover property (@(posedge sys_clk) disable iff (sys_rst)
		conv_done && result_left_justify);
	c_rpt8: cover property (@(posedge sys_clk) disable iff (sys_rst)
		conv_done && accumulate_repeat_select == `ADCFMT_RPT_8);
	c_race: cover property (@(posedge sys_clk) disable iff (sys_rst)
		conv_done && (wr_low || wr_high));

endmodule : adcfmt_result_regs
`default_nettype wire

/* File: adcfmt_result_regs_tb.sv */
// Self-checking testbench for the result formatting registers
`timescale 1ns/1ns
`default_nettype none
`include "adcfmt_consts.svh"

module adcfmt_result_regs_tb;
	import adcfmt_pkg::*;

	typedef struct packed {
		logic [15:0] acc;
		logic        lj;
		logic [1:0]  rpt;
		logic [7:0]  hi;
		logic [7:0]  lo;
	} adcfmt_row_t;

	logic        sys_clk;
	logic        sys_rst;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic [7:0]  sfr_wdata;
	logic        sfr_rd;
	logic [7:0]  sfr_rdata_q;
	logic [15:0] acc_result;
	logic        conv_done;
	logic        conv_start;
	logic        result_left_justify;
	logic [1:0]  accumulate_repeat_select;
	logic        burst_mode_enable;
	logic        converter_enable;
	logic [1:0]  track_mode_select;
	logic [1:0]  post_track_time;
	logic        converter_power_on;
	logic        conv_go;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          m;
	logic        p;
	logic [7:0]  d;

	// Ordinary formatting cases: result, justify, repeat, high, low
	adcfmt_row_t rows [7] = '{
		'{16'h0ABC, 1'b0, `ADCFMT_RPT_1, 8'h0A, 8'hBC},
		'{16'hFFFF, 1'b0, `ADCFMT_RPT_1, 8'h0F, 8'hFF},
		'{16'hFFFF, 1'b0, `ADCFMT_RPT_4, 8'h3F, 8'hFF},
		'{16'hFFFF, 1'b0, `ADCFMT_RPT_8, 8'h7F, 8'hFF},
		'{16'hA5C3, 1'b0, `ADCFMT_RPT_16, 8'hA5, 8'hC3},
		'{16'h0ABC, 1'b1, `ADCFMT_RPT_1, 8'hAB, 8'hC0},
		'{16'h0F35, 1'b1, `ADCFMT_RPT_1, 8'hF3, 8'h50}
	};

	adcfmt_result_regs uut (
		.sys_clk                  (sys_clk),
		.sys_rst                  (sys_rst),
		.sfr_addr                 (sfr_addr),
		.sfr_wr                   (sfr_wr),
		.sfr_wdata                (sfr_wdata),
		.sfr_rd                   (sfr_rd),
		.sfr_rdata_q              (sfr_rdata_q),
		.acc_result               (acc_result),
		.conv_done                (conv_done),
		.conv_start               (conv_start),
		.result_left_justify      (result_left_justify),
		.accumulate_repeat_select (accumulate_repeat_select),
		.burst_mode_enable        (burst_mode_enable),
		.converter_enable         (converter_enable),
		.track_mode_select        (track_mode_select),
		.post_track_time          (post_track_time),
		.converter_power_on       (converter_power_on),
		.conv_go                  (conv_go)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		sfr_addr  <= a;
		sfr_wdata <= v;
		sfr_wr    <= 1'b1;
		@(posedge sys_clk);
		sfr_wr    <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge sys_clk);
		sfr_rd   <= 1'b0;
		#1;
		v = sfr_rdata_q;
	endtask : reg_rd

	// One finished result with its formatting selects
	task automatic conv(input logic [15:0] a, input logic lj,
		input logic [1:0] rpt);
		@(posedge sys_clk);
		acc_result               <= a;
		result_left_justify      <= lj;
		accumulate_repeat_select <= rpt;
		conv_done                <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
	endtask : conv

	// Start pulse; cycles until the go pulse, power level one cycle on
	task automatic start_go(output int cyc, output logic pw);
		@(posedge sys_clk);
		conv_start <= 1'b1;
		@(posedge sys_clk);
		conv_start <= 1'b0;
		#1;
		cyc = 1;
		pw = converter_power_on;
		while (conv_go !== 1'b1 && cyc < 200) begin
			@(posedge sys_clk);
			#1;
			cyc++;
		end
	endtask : start_go

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Watchdog
	initial begin
		#(40 * 4000);
		n_mismatch++;
		give_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_rd = 1'b0;
		acc_result = 16'h0000;
		conv_done = 1'b0;
		conv_start = 1'b0;
		result_left_justify = 1'b0;
		accumulate_repeat_select = 2'h0;
		burst_mode_enable = 1'b0;
		converter_enable = 1'b0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// Reset values
		reg_rd(`ADCFMT_ADDR_TRACK, d);
		chk(d, 8'hFF);
		chk({6'h00, track_mode_select, post_track_time}, 8'h0F);
		reg_rd(`ADCFMT_ADDR_LOW, d);
		chk(d, 8'h00);
		reg_rd(`ADCFMT_ADDR_HIGH, d);
		chk(d, `ADCFMT_RST_HIGH);
		// Table of formatting cases
		foreach (rows[i]) begin
			conv(rows[i].acc, rows[i].lj, rows[i].rpt);
			reg_rd(`ADCFMT_ADDR_HIGH, d);
			chk(d, rows[i].hi);
			reg_rd(`ADCFMT_ADDR_LOW, d);
			chk(d, rows[i].lo);
		end
		// Back-to-back results, the later one stands
		conv(16'h0111, 1'b0, `ADCFMT_RPT_1);
		conv(16'h0222, 1'b0, `ADCFMT_RPT_1);
		reg_rd(`ADCFMT_ADDR_HIGH, d);
		chk(d, 8'h02);
		reg_rd(`ADCFMT_ADDR_LOW, d);
		chk(d, 8'h22);
		// Software write colliding with a finished result
		@(posedge sys_clk);
		sfr_addr <= `ADCFMT_ADDR_HIGH;
		sfr_wdata <= 8'h55;
		sfr_wr <= 1'b1;
		acc_result <= 16'h0123;
		conv_done <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		conv_done <= 1'b0;
		reg_rd(`ADCFMT_ADDR_HIGH, d);
		chk(d, 8'h01);
		reg_rd(`ADCFMT_ADDR_LOW, d);
		chk(d, 8'h23);
		// Plain software write, unmapped place, config fields
		reg_wr(`ADCFMT_ADDR_LOW, 8'h77);
		reg_rd(`ADCFMT_ADDR_LOW, d);
		chk(d, 8'h77);
		reg_wr(`ADCFMT_ADDR_TRACK, 8'h5A);
		#1;
		chk({6'h00, track_mode_select, post_track_time}, 8'h0A);
		reg_wr(8'hC0, 8'h12);
		reg_rd(8'hC0, d);
		chk(d, `ADCFMT_RD_UNMAPPED);
		reg_rd(`ADCFMT_ADDR_TRACK, d);
		chk(d, 8'h5A);
		// Config write, read straight after, value seen next cycle
		@(posedge sys_clk);
		sfr_addr <= `ADCFMT_ADDR_TRACK;
		sfr_wdata <= 8'hA5;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1;
		chk(sfr_rdata_q, 8'hA5);
		chk({6'h00, track_mode_select, post_track_time}, 8'h05);
		// Non-burst, then burst with converter enabled
		@(posedge sys_clk);
		converter_enable <= 1'b1;
		repeat (2) @(posedge sys_clk);
		start_go(m, p);
		chk(8'(m), 8'h01);
		@(posedge sys_clk);
		burst_mode_enable <= 1'b1;
		start_go(m, p);
		chk(8'(m), 8'h01);
		chk({7'h00, p}, 8'h01);
		conv(16'h0001, 1'b0, `ADCFMT_RPT_1);
		#1;
		chk({7'h00, converter_power_on}, 8'h01);
		// Burst with converter disabled: power-up per start, delayed go
		reg_wr(`ADCFMT_ADDR_TRACK, 8'h0F);
		@(posedge sys_clk);
		converter_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({7'h00, converter_power_on}, 8'h00);
		start_go(m, p);
		chk({7'h00, p}, 8'h01);
		chk(8'(m), 8'(`ADCFMT_PWR_STEP_CYC + 1));
		conv(16'h0002, 1'b0, `ADCFMT_RPT_1);
		#1;
		chk({7'h00, converter_power_on}, 8'h00);
		reg_wr(`ADCFMT_ADDR_TRACK, 8'h1F);
		start_go(m, p);
		chk(8'(m), 8'(2 * `ADCFMT_PWR_STEP_CYC + 1));
		conv(16'h0003, 1'b0, `ADCFMT_RPT_1);
		// Reset in mid-run restores every register
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk({7'h00, converter_power_on}, 8'h00);
		reg_rd(`ADCFMT_ADDR_TRACK, d);
		chk(d, `ADCFMT_RST_TRACK);
		reg_rd(`ADCFMT_ADDR_LOW, d);
		chk(d, `ADCFMT_RST_LOW);
		reg_rd(`ADCFMT_ADDR_HIGH, d);
		chk(d, `ADCFMT_RST_HIGH);
		give_verdict();
	end

endmodule : adcfmt_result_regs_tb

`default_nettype wire
